// file: logic/uch_regs.sv
// Purpose: Register file of one serial channel on the parallel host port.
// Assumes: Host strobes are generated on clk_sys; modem pins are async.
// Notes: Shift engines and baud generator sit outside this block.
// Summary of operation
// [RL1] Four address bits select sixteen byte registers.
// [RL2] Divisor bit swaps offsets 0-2 to divisor latches.
// [RL3] Enhanced bits writable only with enhanced enable.
// [RL4] Flow character flags clear after being read; the code clears them only while the divisor bit is clear.
// [RL5] Modem-control bits 2,3 drive no pins.
// [RL6] Interrupt enable masks each of five sources.
// [RL7] Pending interrupt shown in status and summary.
// [RL8] Receive interrupt when fill reaches trigger.
// [RL9] Receive interrupt drops below trigger level.
// [RL10] Status code follows receive trigger condition.
// [RL11] Data ready sets on character push.
// [RL12] Data ready clears only when queue empty.
// [RL13] Reserved offsets read zero, ignore writes.
`timescale 1ns/1ps
module uch_regs #(
    parameter int RX_DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic chan_reset,
    input wire logic cs_n,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    input wire logic rx_push,
    input wire logic [7:0] rx_char,
    input wire logic [3:0] line_err_in,
    input wire logic rx_queue_err_in,
    input wire logic tx_queue_empty_in,
    input wire logic tx_idle_in,
    input wire logic [3:0] flow_event_in,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic ri_n,
    input wire logic cd_n,
    output logic rts_n,
    output logic dtr_n,
    output logic tx_load,
    output logic [7:0] tx_char,
    output logic tx_queue_reset,
    output logic [15:0] baud_divisor,
    output logic [3:0] baud_fraction,
    output logic [7:0] cfg_line_control,
    output logic [7:0] cfg_modem_control,
    output logic [7:0] cfg_queue_control,
    output logic [7:0] cfg_feature_control,
    output logic [7:0] cfg_enhanced_function,
    output logic [7:0] cfg_modem_write,
    output logic [7:0] stop_char_1,
    output logic [7:0] stop_char_2,
    output logic [7:0] resume_char_1,
    output logic [7:0] resume_char_2,
    output logic irq_out,
    output logic irq_summary
);
    import uch_pkg::*;

    localparam int CW = $clog2(RX_DEPTH) + 1;

    // The trigger table tops out at 28 entries.
    if (RX_DEPTH < 32) begin : g_chk
        $error("uch_regs: RX_DEPTH must be at least 32");
    end
    // Stored registers.
    logic [7:0] div_low_reg, div_high_reg, div_frac_reg; // Divisor bank.
    logic [7:0] ier_reg, qc_reg, lcr_reg, mcr_reg; // Classic controls.
    logic [7:0] spr_reg, feature_control_reg, efr_reg, mwr_reg; // Scratch, enhanced.
    logic [7:0] stop1_reg, stop2_reg, res1_reg, res2_reg; // Flow characters.
    logic [7:0] tx_char_reg, dout_reg; // Transmit byte and read data.
    logic tx_load_reg, txrst_reg, summary_reg; // Strobes and summary.
    logic rd_act_q, wr_act_q; // Strobes seen last cycle.
    logic [3:0] modem_s1, modem_s2, modem_q; // Sync stages, last state.

    // Host strobes: an access is taken on its first low cycle.
    wire rd_act = ~cs_n & ~ior_n;
    wire wr_act = ~cs_n & ~iow_n;
    wire rd_pulse = rd_act & ~rd_act_q;
    wire wr_pulse = wr_act & ~wr_act_q;
    // Address decode shared by the read and the write paths.
    wire div_sel = lcr_reg[LCR_DIV_BIT];
    wire enh = efr_reg[EFR_ENH_BIT];
    wire loop_en = mcr_reg[MCR_LOOP_BIT];
    wire a_hold = (addr == OFF_HOLD); // [RL1]
    wire a_ier = (addr == OFF_IER);
    wire a_isr = (addr == OFF_ISR);
    wire a_lsr = (addr == OFF_LSR);
    wire a_msr = (addr == OFF_MSR);
    wire a_xchr = (addr == OFF_XCHAR);
    wire lo_div = div_sel & (a_hold | a_ier | a_isr); // [RL2]
    wire wr_go = wr_pulse & ~chan_reset;
    // Write masks widen when enhanced functions are unlocked.
    wire [7:0] ier_mask = enh ? (IER_BASE_MASK | IER_ENH_MASK)
                              : IER_BASE_MASK; // [RL3]
    wire [7:0] mcr_mask = enh ? (MCR_BASE_MASK | MCR_ENH_MASK)
                              : MCR_BASE_MASK; // [RL3]
    wire [7:0] qc_mask = enh ? 8'hff : ~QC_ENH_MASK; // [RL3]
    // Receive queue and its status.
    wire [7:0] rx_head;
    wire [CW-1:0] rx_count;
    wire rx_empty;
    wire rx_over;
    wire rx_pop = rd_pulse & a_hold & ~div_sel & ~rx_empty;
    wire rx_flush = chan_reset
                    | (wr_go & a_isr & ~div_sel & data_in[QC_RXRST_BIT]);
    uch_rx_fifo #(
        .WIDTH(8),
        .DEPTH(RX_DEPTH)
    ) u_rx_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .flush(rx_flush),
        .push(rx_push),
        .push_data(rx_char),
        .pop(rx_pop),
        .head(rx_head),
        .count(rx_count),
        .empty(rx_empty),
        .overrun(rx_over)
    );
    // Sticky line errors, cleared by a line-status read.
    wire [3:0] line_err;
    wire [3:0] err_set = line_err_in | {3'h0, rx_over};
    uch_sticky #(.N(4)) u_line_err (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .chan_reset(chan_reset),
        .set_pulse(err_set),
        .clr_pulse(rd_pulse & a_lsr),
        .flags(line_err)
    );
    // Modem inputs: in loopback the outputs feed back internally.
    // Bits 2 and 3 reach only the loopback path, never a pin.
    wire [3:0] modem_now = loop_en
        ? {mcr_reg[3], mcr_reg[2], mcr_reg[0], mcr_reg[1]} // [RL5]
        : ~modem_s2;
    wire [3:0] modem_delta;
    uch_sticky #(.N(4)) u_modem_delta (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .chan_reset(chan_reset),
        .set_pulse(modem_now ^ modem_q),
        .clr_pulse(rd_pulse & a_msr),
        .flags(modem_delta)
    );
    // Flow character status flags, self-clearing on a read with the divisor bit clear.
    wire [3:0] flow_flags;
    uch_sticky #(.N(4)) u_flow (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .chan_reset(chan_reset),
        .set_pulse(flow_event_in),
        .clr_pulse(rd_pulse & a_xchr & ~div_sel), // [RL4]
        .flags(flow_flags)
    );
    // Interrupt sources, each gated by its enable bit.
    wire q_en = qc_reg[QC_EN_BIT];
    wire [5:0] trig = rx_trig_level(qc_reg[7:6]);
    wire rx_level = q_en ? (rx_count >= CW'(trig)) : ~rx_empty; // [RL8]
    wire rx_src = ier_reg[0] & rx_level; // [RL6] [RL9]
    wire tx_src = ier_reg[1] & tx_queue_empty_in; // [RL6]
    wire ls_src = ier_reg[2] & (|line_err); // [RL6]
    wire ms_src = ier_reg[3] & (|modem_delta); // [RL6]
    wire fc_src = enh & ier_reg[5] & flow_flags[0];
    wire pend = rx_src | tx_src | ls_src | ms_src | fc_src;

    // Highest pending source selects the status code.
    wire [3:0] isr_code = ls_src ? ISR_LSR
                        : rx_src ? ISR_RXRDY // [RL10]
                        : tx_src ? ISR_TXRDY
                        : ms_src ? ISR_MSR
                        : fc_src ? ISR_MSR
                        : ISR_NONE; // [RL7]
    wire fc_top = fc_src & ~(ls_src | rx_src | tx_src | ms_src);
    wire [7:0] isr_val = {q_en, q_en, 1'b0, fc_top & enh, isr_code};
    wire [7:0] lsr_val = {rx_queue_err_in, tx_idle_in, tx_queue_empty_in,
                          line_err, ~rx_empty}; // [RL11] [RL12]
    wire [7:0] msr_val = {modem_now, modem_delta};

    // Read multiplexer; reserved offsets return zero.
    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = READ_ZERO;
        unique case (addr)
            OFF_HOLD: rd_mux = div_sel ? div_low_reg
                             : (rx_empty ? READ_ZERO : rx_head);
            OFF_IER: rd_mux = div_sel ? div_high_reg : ier_reg;
            OFF_ISR: rd_mux = div_sel ? div_frac_reg : isr_val;
            OFF_LCR: rd_mux = lcr_reg;
            OFF_MCR: rd_mux = mcr_reg;
            OFF_LSR: rd_mux = lsr_val;
            OFF_MSR: rd_mux = msr_val;
            OFF_SPR: rd_mux = spr_reg;
            OFF_FEATURE_CONTROL: rd_mux = feature_control_reg;
            OFF_EFR: rd_mux = efr_reg;
            OFF_XCHAR: rd_mux = {4'h0, flow_flags};
            default: rd_mux = READ_ZERO; // [RL13]
        endcase
    end

    // Strobe history, synchroniser, transmit strobes and read data.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            modem_s1 <= 4'hf;
            modem_s2 <= 4'hf;
            modem_q <= 4'h0;
            dout_reg <= READ_ZERO;
            summary_reg <= 1'b0;
            tx_load_reg <= 1'b0;
            txrst_reg <= 1'b0;
        end
        else
        begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            modem_s1 <= {cd_n, ri_n, dsr_n, cts_n};
            modem_s2 <= modem_s1;
            modem_q <= modem_now;
            summary_reg <= pend; // [RL7]
            tx_load_reg <= wr_go & a_hold & ~div_sel;
            txrst_reg <= wr_go & a_isr & ~div_sel & data_in[QC_TXRST_BIT];
            if (rd_pulse)
                dout_reg <= rd_mux;
        end
    end

    // Configuration registers; reserved offsets have no write path.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {div_low_reg, div_high_reg, div_frac_reg} <= {3{REG_RESET}};
            {ier_reg, qc_reg, lcr_reg, mcr_reg} <= {4{REG_RESET}};
            {spr_reg, feature_control_reg, efr_reg, mwr_reg} <= {4{REG_RESET}};
            {stop1_reg, stop2_reg, res1_reg, res2_reg} <= {4{REG_RESET}};
            tx_char_reg <= REG_RESET;
        end
        else if (chan_reset) // Synchronous, kept out of the async branch.
            {div_low_reg, div_high_reg, div_frac_reg, ier_reg, qc_reg,
             lcr_reg, mcr_reg, spr_reg, feature_control_reg, efr_reg, mwr_reg, stop1_reg,
             stop2_reg, res1_reg, res2_reg, tx_char_reg} <= {16{REG_RESET}};
        else if (wr_go)
        begin
            unique case (addr)
                OFF_HOLD:
                    if (div_sel)
                        div_low_reg <= data_in; // [RL2]
                    else
                        tx_char_reg <= data_in;
                OFF_IER:
                    if (div_sel)
                        div_high_reg <= data_in;
                    else
                        ier_reg <= data_in & ier_mask; // [RL3]
                OFF_ISR:
                    if (div_sel)
                        div_frac_reg <= data_in & DLD_MASK;
                    else
                        qc_reg <= (data_in & qc_mask)
                                | (qc_reg & ~qc_mask); // [RL3]
                OFF_LCR: lcr_reg <= data_in;
                OFF_MCR: mcr_reg <= (data_in & mcr_mask)
                                  | (mcr_reg & ~mcr_mask); // [RL3]
                OFF_MSR:
                    if (enh)
                        mwr_reg <= data_in; // [RL3]
                OFF_SPR: spr_reg <= data_in; // [RL1]
                OFF_FEATURE_CONTROL: feature_control_reg <= data_in & FEATURE_CONTROL_MASK;
                OFF_EFR: efr_reg <= data_in;
                OFF_XCHAR: stop1_reg <= data_in;
                OFF_STOP2: stop2_reg <= data_in;
                OFF_RES1: res1_reg <= data_in;
                OFF_RES2: res2_reg <= data_in;
                default: ; // Reserved offsets ignore writes. [RL13]
            endcase
        end
    end

    // Output drive.
    assign data_out = dout_reg;
    assign data_oe = rd_act & rd_act_q;
    assign rts_n = loop_en | ~mcr_reg[1]; // [RL5]
    assign dtr_n = loop_en | ~mcr_reg[0]; // [RL5]
    assign tx_load = tx_load_reg;
    assign tx_char = tx_char_reg;
    assign tx_queue_reset = txrst_reg;
    assign baud_divisor = {div_high_reg, div_low_reg};
    assign baud_fraction = div_frac_reg[3:0];
    assign cfg_line_control = lcr_reg;
    assign cfg_modem_control = mcr_reg;
    assign cfg_queue_control = qc_reg;
    assign cfg_feature_control = feature_control_reg;
    assign cfg_enhanced_function = efr_reg;
    assign cfg_modem_write = mwr_reg;
    assign stop_char_1 = stop1_reg;
    assign stop_char_2 = stop2_reg;
    assign resume_char_1 = res1_reg;
    assign resume_char_2 = res2_reg;
    assign irq_out = pend; // [RL6]
    assign irq_summary = summary_reg;

    // Checks next to the logic they guard.
    AST_SCRATCH_DECODE: assert property (@(posedge clk_sys) // [RL1]
        disable iff (!reset_n)
        wr_go && addr == OFF_SPR |=> spr_reg == $past(data_in))
        else $error("scratch write not decoded");
    AST_DIV_READ: assert property (@(posedge clk_sys) // [RL2]
        disable iff (!reset_n)
        rd_pulse && lo_div && a_ier |=> data_out == $past(div_high_reg))
        else $error("divisor bank not selected");
    AST_ENH_LOCK: assert property (@(posedge clk_sys) // [RL3]
        disable iff (!reset_n)
        wr_go && a_ier && !div_sel && !enh && !chan_reset
        |=> ier_reg[7:5] == 3'h0)
        else $error("enhanced enable bits written while locked");
    AST_PIN_FREE: assert property (@(posedge clk_sys) // [RL5]
        disable iff (!reset_n)
        $stable(mcr_reg[1:0]) && $stable(loop_en)
        |-> $stable(rts_n) && $stable(dtr_n))
        else $error("modem pins moved without their bits");
    AST_MASKED: assert property (@(posedge clk_sys) // [RL6]
        disable iff (!reset_n)
        ier_reg[3:0] == 4'h0 && !ier_reg[5] |-> !irq_out)
        else $error("masked source reached the interrupt");
    AST_SUMMARY: assert property (@(posedge clk_sys) // [RL7]
        disable iff (!reset_n)
        irq_out |=> irq_summary)
        else $error("summary bit missed a pending interrupt");
    AST_RX_TRIGGER: assert property (@(posedge clk_sys) // [RL8]
        disable iff (!reset_n)
        q_en && ier_reg[0] && rx_count >= CW'(trig) |-> irq_out)
        else $error("receive trigger did not interrupt");
    AST_RX_BELOW: assert property (@(posedge clk_sys) // [RL9]
        disable iff (!reset_n)
        q_en && rx_count < CW'(trig) |-> !rx_src)
        else $error("receive interrupt held below trigger");
    AST_RX_CODE: assert property (@(posedge clk_sys) // [RL10]
        disable iff (!reset_n)
        rx_src && !ls_src |-> isr_code == ISR_RXRDY)
        else $error("status code lost receive trigger");
    AST_READY_SET: assert property (@(posedge clk_sys) // [RL11]
        disable iff (!reset_n)
        rx_push && !rx_flush |=> lsr_val[0])
        else $error("data ready not set on push");
    AST_READY_CLR: assert property (@(posedge clk_sys) // [RL12]
        disable iff (!reset_n)
        $fell(lsr_val[0]) |-> rx_count == '0)
        else $error("data ready cleared with data queued");
    AST_RSVD_READ: assert property (@(posedge clk_sys) // [RL13]
        disable iff (!reset_n)
        rd_pulse && (addr == OFF_RSVA || addr == OFF_RSVB)
        |=> data_out == READ_ZERO)
        else $error("reserved offset read non-zero");
endmodule // uch_regs

// file: pkg/uch_pkg.sv
// Purpose: Shared constants for one serial channel register block.
// Assumes: Byte-wide registers decoded from four address bits.
// Notes: Trigger levels are plain defaults for a 32-entry receive queue.
package uch_pkg;
    // Register offsets within the channel.
    localparam logic [3:0] OFF_HOLD = 4'h0;
    localparam logic [3:0] OFF_IER = 4'h1;
    localparam logic [3:0] OFF_ISR = 4'h2;
    localparam logic [3:0] OFF_LCR = 4'h3;
    localparam logic [3:0] OFF_MCR = 4'h4;
    localparam logic [3:0] OFF_LSR = 4'h5;
    localparam logic [3:0] OFF_MSR = 4'h6;
    localparam logic [3:0] OFF_SPR = 4'h7;
    localparam logic [3:0] OFF_FEATURE_CONTROL = 4'h8;
    localparam logic [3:0] OFF_EFR = 4'h9;
    localparam logic [3:0] OFF_RSVA = 4'ha;
    localparam logic [3:0] OFF_RSVB = 4'hb;
    localparam logic [3:0] OFF_XCHAR = 4'hc;
    localparam logic [3:0] OFF_STOP2 = 4'hd;
    localparam logic [3:0] OFF_RES1 = 4'he;
    localparam logic [3:0] OFF_RES2 = 4'hf;
    // Field positions.
    localparam int LCR_DIV_BIT = 7;
    localparam int EFR_ENH_BIT = 4;
    localparam int MCR_LOOP_BIT = 4;
    localparam int QC_EN_BIT = 0;
    localparam int QC_RXRST_BIT = 1;
    localparam int QC_TXRST_BIT = 2;
    // Writable bit masks, base set and enhanced set.
    localparam logic [7:0] IER_BASE_MASK = 8'h0f;
    localparam logic [7:0] IER_ENH_MASK = 8'he0;
    localparam logic [7:0] MCR_BASE_MASK = 8'h13;
    localparam logic [7:0] MCR_ENH_MASK = 8'hec;
    localparam logic [7:0] QC_ENH_MASK = 8'h30;
    localparam logic [7:0] FEATURE_CONTROL_MASK = 8'h30;
    localparam logic [7:0] DLD_MASK = 8'h0f;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // Interrupt source codes.
    localparam logic [3:0] ISR_NONE = 4'h1;
    localparam logic [3:0] ISR_LSR = 4'h6;
    localparam logic [3:0] ISR_RXRDY = 4'h4;
    localparam logic [3:0] ISR_TXRDY = 4'h2;
    localparam logic [3:0] ISR_MSR = 4'h0;
    // Receive trigger level selected by the two top queue-control bits.
    function automatic logic [5:0] rx_trig_level(input logic [1:0] sel);
        logic [5:0] lvl;
        lvl = 6'h08;
        unique case (sel)
            2'h0: lvl = 6'h08;
            2'h1: lvl = 6'h10;
            2'h2: lvl = 6'h18;
            2'h3: lvl = 6'h1c;
        endcase
        return lvl;
    endfunction
endpackage

// file: logic/uch_sticky.sv
// Purpose: Bank of sticky flags set by hardware, cleared by a read.
// Assumes: Set and clear pulses come from the system clock domain.
// Notes: A set arriving with the clear keeps the flag.
`timescale 1ns/1ps
module uch_sticky #(
    parameter int N = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic chan_reset,
    input wire logic [N-1:0] set_pulse,
    input wire logic clr_pulse,
    output logic [N-1:0] flags
);
    import uch_pkg::*;

    // Refuse an empty bank.
    if (N < 1) begin : g_chk
        $error("uch_sticky: N must be at least one");
    end

    // One flag per bit; the set term wins over the read clear.
    for (genvar i = 0; i < N; i++) begin : g_bit
        always_ff @(posedge clk_sys or negedge reset_n)
        begin
            if (!reset_n)
                flags[i] <= 1'b0;
            else if (chan_reset)
                flags[i] <= 1'b0;
            else
                flags[i] <= set_pulse[i] | (flags[i] & ~clr_pulse); // [RL4]
        end
    end

    // A read with no new event leaves every flag clear.
    AST_STICKY_CLEAR: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clr_pulse && !chan_reset |=> flags == $past(set_pulse)) // [RL4]
        else $error("sticky flags not cleared by read");
endmodule // uch_sticky

// file: logic/uch_rx_fifo.sv
// Purpose: Receive queue holding characters until the host reads them.
// Assumes: Push and pop are single-cycle pulses on the system clock.
// Notes: A push into a full queue is dropped and flagged as overrun.
`timescale 1ns/1ps
module uch_rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic [WIDTH-1:0] head,
    output logic [$clog2(DEPTH):0] count,
    output logic empty,
    output logic overrun
);
    localparam int AW = $clog2(DEPTH);

    // The pointers wrap naturally, so the depth must be a power of two.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("uch_rx_fifo: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH]; // Character storage.
    logic [AW-1:0] wr_ptr; // Next slot to fill.
    logic [AW-1:0] rd_ptr; // Oldest character.
    wire full = (count == (AW+1)'(DEPTH));
    wire do_push = push & ~full;
    wire do_pop = pop & ~empty;

    assign empty = (count == '0);
    assign head = mem[rd_ptr];
    assign overrun = push & full;

    // Storage write; no reset needed for data.
    always_ff @(posedge clk_sys)
    begin
        if (do_push)
            mem[wr_ptr] <= push_data;
    end

    // Pointer and fill count bookkeeping.
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else if (flush)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + AW'(do_push);
            rd_ptr <= rd_ptr + AW'(do_pop);
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule // uch_rx_fifo

// file: verif/uch_host.sv
// Purpose: Host processor model on the parallel register port.
// Assumes: Strobes change 1 ns after a rising edge of clk_sys.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
module uch_host (
    input wire logic clk_sys,
    output logic cs_n,
    output logic ior_n,
    output logic iow_n,
    output logic [3:0] addr,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    // The bus is idle at time zero.
    initial
    begin
        cs_n = 1'b1;
        ior_n = 1'b1;
        iow_n = 1'b1;
        addr = 4'h0;
        data_in = 8'h00;
    end

    // One access; strobe held two edges, q is {data_oe, data_out}.
    task automatic acc(input logic w, input logic [3:0] a,
        input logic [7:0] d, output logic [8:0] q);
        @(posedge clk_sys);
        #1;
        addr = a;
        data_in = d;
        cs_n = 1'b0;
        ior_n = w;
        iow_n = !w;
        repeat (2) @(posedge clk_sys);
        q = {data_oe, data_out};
        #1;
        cs_n = 1'b1;
        ior_n = 1'b1;
        iow_n = 1'b1;
        addr = ~addr;
        data_in = ~data_in;
    endtask
endmodule // uch_host

// file: verif/uch_regs_test.sv
// Purpose: Self-checking bench for the channel register block.
// Assumes: Host model drives the port; bench drives the channel side.
// Notes: Random values come from a fixed seed.
`timescale 1ns/1ps
module uch_regs_test;
    import uch_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic chan_reset = 1'b0;
    logic cs_n, ior_n, iow_n, data_oe, rx_push = 1'b0;
    logic [3:0] addr, flow_event_in = 4'h0;
    logic [7:0] data_in, data_out, rx_char = 8'h00;
    logic tx_queue_empty_in = 1'b0, cts_n = 1'b1, dsr_n = 1'b1;
    logic ri_n = 1'b1, cd_n = 1'b1, rts_n, dtr_n, irq_out, irq_summary;
    logic [15:0] baud_divisor;
    logic [3:0] baud_fraction;
    logic [7:0] mwr;
    logic [7:0] q [8];
    logic [31:0] v;
    logic [8:0] r;
    int err_total = 0, tests_run = 0, cycles = 0;
    always #5 clk_sys = ~clk_sys;
    uch_host i_uch_host (.clk_sys(clk_sys), .cs_n(cs_n), .ior_n(ior_n),
        .iow_n(iow_n), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe));
    uch_regs i_uch_regs (.clk_sys(clk_sys), .reset_n(reset_n),
        .chan_reset(chan_reset), .cs_n(cs_n), .ior_n(ior_n),
        .iow_n(iow_n), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .rx_push(rx_push),
        .rx_char(rx_char), .line_err_in(4'h0), .rx_queue_err_in(1'b0),
        .tx_queue_empty_in(tx_queue_empty_in), .tx_idle_in(1'b0),
        .flow_event_in(flow_event_in), .cts_n(cts_n), .dsr_n(dsr_n),
        .ri_n(ri_n), .cd_n(cd_n), .rts_n(rts_n), .dtr_n(dtr_n),
        .tx_load(), .tx_char(), .tx_queue_reset(),
        .baud_divisor(baud_divisor), .baud_fraction(baud_fraction),
        .cfg_line_control(), .cfg_modem_control(), .cfg_queue_control(),
        .cfg_feature_control(), .cfg_enhanced_function(),
        .cfg_modem_write(mwr), .stop_char_1(), .stop_char_2(),
        .resume_char_1(), .resume_char_2(), .irq_out(irq_out),
        .irq_summary(irq_summary));
    // Compares one value and counts it.
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_uch_host.acc(1'b1, a, d, r);
    endtask
    // Reads and expects the data bus to be driven.
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        i_uch_host.acc(1'b0, a, 8'h00, r);
        chk(r, {1'b1, e});
    endtask
    task automatic push(input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        rx_push = 1'b1;
        rx_char = d;
        @(posedge clk_sys);
        #1;
        rx_push = 1'b0;
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Guards against a hang.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            test_done();
        end
    end
    initial
    begin
        v = $urandom(32'hb17e9bdc);
        repeat (2) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        rdc(OFF_LCR, 8'h00);
        rdc(OFF_IER, 8'h00);
        chk({7'h0, rts_n, dtr_n}, 9'h003);
        for (int i = 0; i < 4; i++)
        begin
            v = $urandom;
            {cts_n, dsr_n, ri_n, cd_n} = v[11:8];
            wr(OFF_SPR, v[7:0]);
            wr(OFF_RSVA, ~v[7:0]);
            wr(OFF_RSVB, v[7:0]);
            rdc(OFF_SPR, v[7:0]);
            rdc(OFF_RSVA, READ_ZERO);
            rdc(OFF_RSVB, READ_ZERO);
        end
        $display("map done");
        wr(OFF_LCR, 8'h80);
        wr(OFF_HOLD, v[7:0]);
        wr(OFF_IER, v[15:8]);
        wr(OFF_ISR, v[23:16]);
        chk({5'h0, baud_fraction}, {5'h0, v[19:16]});
        chk(baud_divisor[8:0], v[8:0]);
        rdc(OFF_ISR, {4'h0, v[19:16]});
        rdc(OFF_IER, v[15:8]);
        wr(OFF_LCR, 8'h03);
        rdc(OFF_IER, 8'h00);
        $display("divisor done");
        wr(OFF_IER, 8'hff);
        rdc(OFF_IER, 8'h0f);
        wr(OFF_MCR, 8'hef);
        rdc(OFF_MCR, 8'h03);
        chk({7'h0, rts_n, dtr_n}, 9'h000);
        wr(OFF_MSR, 8'h5a);
        chk({1'b0, mwr}, 9'h000);
        wr(OFF_EFR, 8'h10);
        wr(OFF_MSR, 8'h5a);
        chk({1'b0, mwr}, 9'h05a);
        wr(OFF_IER, 8'hff);
        rdc(OFF_IER, 8'hef);
        wr(OFF_MCR, 8'h0c);
        rdc(OFF_MCR, 8'h0c);
        chk({7'h0, rts_n, dtr_n}, 9'h003);
        wr(OFF_MCR, 8'h13);
        chk({7'h0, rts_n, dtr_n}, 9'h003);
        wr(OFF_IER, 8'h00);
        $display("enhanced done");
        @(posedge clk_sys);
        #1;
        flow_event_in = v[27:24] | 4'h1;
        @(posedge clk_sys);
        #1;
        flow_event_in = 4'h0;
        rdc(OFF_XCHAR, {4'h0, v[27:24] | 4'h1});
        rdc(OFF_XCHAR, 8'h00);
        $display("flow done");
        wr(OFF_ISR, 8'h01);
        wr(OFF_IER, 8'h01);
        for (int i = 0; i < 8; i++)
        begin
            q[i] = 8'($urandom);
            push(q[i]);
            if (i == 0)
                rdc(OFF_LSR, 8'h01);
            chk({8'h0, irq_out}, {8'h0, i == 7});
        end
        rdc(OFF_ISR, 8'hc4);
        chk({8'h0, irq_summary}, 9'h001);
        wr(OFF_IER, 8'h00);
        chk({8'h0, irq_out}, 9'h000);
        tx_queue_empty_in = 1'b1;
        wr(OFF_IER, 8'h02);
        rdc(OFF_ISR, 8'hc2);
        tx_queue_empty_in = 1'b0;
        wr(OFF_IER, 8'h01);
        rdc(OFF_HOLD, q[0]);
        chk({8'h0, irq_out}, 9'h000);
        rdc(OFF_ISR, 8'hc1);
        for (int i = 1; i < 8; i++)
        begin
            rdc(OFF_LSR, 8'h01);
            rdc(OFF_HOLD, q[i]);
        end
        rdc(OFF_LSR, 8'h00);
        $display("receive done");
        wr(OFF_SPR, 8'h5a);
        @(posedge clk_sys);
        #1;
        chan_reset = 1'b1;
        @(posedge clk_sys);
        #1;
        chan_reset = 1'b0;
        rdc(OFF_SPR, REG_RESET);
        $display("channel reset done");
        test_done();
    end
endmodule // uch_regs_test
